//--- src/match_timer_pkg.sv
// constants, register map and types for the free-running match timer
package match_timer_pkg;

   // register byte addresses on the peripheral bus (internal map, chosen offsets)
   localparam logic [3:0] ADDR_COUNT_LO    = 4'h0;  // free_counter low byte
   localparam logic [3:0] ADDR_COUNT_HI    = 4'h1;  // free_counter high byte
   localparam logic [3:0] ADDR_MATCH_LO    = 4'h2;  // match_register low byte
   localparam logic [3:0] ADDR_MATCH_HI    = 4'h3;  // match_register high byte
   localparam logic [3:0] ADDR_SNAP_LO     = 4'h4;  // snapshot_register low byte
   localparam logic [3:0] ADDR_SNAP_HI     = 4'h5;  // snapshot_register high byte
   localparam logic [3:0] ADDR_MODE        = 4'h6;  // mode control byte
   localparam logic [3:0] ADDR_BUZZ        = 4'h7;  // buzzer control byte

   // mode control byte field positions
   localparam int MODE_OUT_EN_BIT   = 0;  // timer output enable
   localparam int MODE_CLK_SEL_LSB  = 1;  // count_clock_sel_lo, _hi at +1
   localparam int MODE_INV_EN_BIT   = 3;  // output_invert_enable
   localparam int MODE_CAP_SEL_LSB  = 4;  // capture_edge_sel_lo, _hi at +1
   localparam int MODE_WRAP_BIT     = 6;  // wrap_flag
   localparam int MODE_OUT_DATA_BIT = 7;  // timer output level, read only

   // buzzer control byte field positions
   localparam int BUZZ_EN_BIT       = 0;  // buzzer output enable
   localparam int BUZZ_SEL_LSB      = 1;  // three-bit frequency select

   // reset values
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] MATCH_RESET = 16'hFFFF;
   localparam logic [7:0]  MODE_RESET  = 8'h00;
   localparam logic [7:0]  BUZZ_RESET  = 8'h00;

   // prescaler taps: system clock divided by 4, 64 and 16
   localparam int PRESCALE_W   = 6;
   localparam int DIV4_TAP     = 2;
   localparam int DIV64_TAP    = 6;
   localparam int DIV16_TAP    = 4;
   // buzzer: toggle period base, count clock divided by 2^4 .. 2^11
   localparam int BUZZ_DIV_W   = 13;
   localparam int BUZZ_MIN_TAP = 4;

   // count clock selection codes
   typedef enum logic [1:0]
   {
      CLK_DIV4  = 2'b00,
      CLK_DIV64 = 2'b01,
      CLK_DIV16 = 2'b10,
      CLK_NONE  = 2'b11
   } clk_sel_e;

   // capture edge selection codes
   typedef enum logic [1:0]
   {
      CAP_OFF  = 2'b00,
      CAP_RISE = 2'b01,
      CAP_FALL = 2'b10,
      CAP_BOTH = 2'b11
   } cap_sel_e;

endpackage

//--- src/count_prescaler.sv
// prescaler that turns the system clock into count-clock enable pulses
`timescale 1ns/1ps
module count_prescaler
   import match_timer_pkg::*;
(
   input  wire logic                   clk_sys,   // system clock
   input  wire logic                   rst_n,     // async reset, active low
   input  wire match_timer_pkg::clk_sel_e sel,    // count clock choice
   output logic                        tick       // one-cycle count enable
);

   ////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed
   {
      logic [PRESCALE_W-1:0] div;   // free-running divider
      logic                  tick;  // registered enable
   } pre_s;

   pre_s s_reg;   // current state
   pre_s s_next;  // next state

   ////////////////////////////////////////////////////////////////////////
   // next state: pulse when the selected low bits roll over
   always_comb
   begin
      s_next     = s_reg;
      s_next.div = s_reg.div + 1'b1;
      case (sel)
         CLK_DIV4:  s_next.tick = (s_reg.div[DIV4_TAP-1:0] == '1);
         CLK_DIV64: s_next.tick = (s_reg.div[DIV64_TAP-1:0] == '1);
         CLK_DIV16: s_next.tick = (s_reg.div[DIV16_TAP-1:0] == '1);
         default:   s_next.tick = 1'b0;  // prohibited code: counter halts
      endcase
   end

   // register
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign tick = s_reg.tick;

endmodule

//--- src/match_timer.sv
// 16-bit free-running timer with match, capture, read buffer and buzzer
`timescale 1ns/1ps
module match_timer
   import match_timer_pkg::*;
(
   input  wire logic        clk_sys,              // 40 MHz system clock
   input  wire logic        rst_n,                // async reset, active low
   input  wire logic [3:0]  addr,                 // byte address of access
   input  wire logic        rd,                   // read strobe
   input  wire logic        wr,                   // write strobe
   input  wire logic        word,                 // 1: 16-bit access at even addr
   input  wire logic [15:0] wdata,                // write data, byte in low lane
   output logic      [15:0] rdata,                // read data, registered
   input  wire logic        capture_trigger_pin,  // capture input
   output logic             match_irq,            // one-cycle match request
   output logic             timer_out_pin,        // timer output
   output logic             buzzer_out_pin        // buzzer square wave
);

   ////////////////////////////////////////////////////////////////////////
   // state of the block in one record; the prescaler divider lives in u_pre
   typedef struct packed
   {
      logic [15:0]           count;     // free_counter
      logic [15:0]           match;     // match_register
      logic [15:0]           snap;      // snapshot_register
      logic [15:0]           rbuf;      // counter read buffer
      logic [7:0]            mode;      // mode control byte
      logic [7:0]            buzz;      // buzzer control byte
      logic                  out_lvl;   // timer output data
      logic                  cap_prev;  // last sampled capture pin
      logic                  irq;       // registered match request
      logic [BUZZ_DIV_W-1:0] bdiv;      // buzzer divider on count ticks
      logic                  bz;        // buzzer wave
      logic [15:0]           rdata;     // read data register
   } tim_s;

   tim_s s_reg;   // current state
   tim_s s_next;  // next state

   logic     tick;      // count clock enable
   clk_sel_e clk_sel;   // decoded count clock field
   cap_sel_e cap_sel;   // decoded capture field
   logic     rise;      // capture pin rising edge
   logic     fall;      // capture pin falling edge
   logic     cap_hit;   // selected capture edge seen
   logic     hit;       // counter equals match register
   logic [2:0] bsel;    // buzzer frequency code
   logic     btap;      // selected buzzer divider rollover
   logic [BUZZ_DIV_W-1:0] bmask;  // divider bits that set the half period
   logic     match_wr;  // write to either match byte

   assign clk_sel = clk_sel_e'(s_reg.mode[MODE_CLK_SEL_LSB +: 2]);
   assign cap_sel = cap_sel_e'(s_reg.mode[MODE_CAP_SEL_LSB +: 2]);
   assign bsel    = s_reg.buzz[BUZZ_SEL_LSB +: 3];

   ////////////////////////////////////////////////////////////////////////
   // count clock prescaler
   count_prescaler u_pre
   (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .sel     (clk_sel),
      .tick    (tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // edge detection on the capture pin, pin taken as synchronous
   always_comb
   begin
      rise = capture_trigger_pin & ~s_reg.cap_prev;
      fall = ~capture_trigger_pin & s_reg.cap_prev;
      case (cap_sel)
         CAP_RISE: cap_hit = rise;
         CAP_FALL: cap_hit = fall;
         CAP_BOTH: cap_hit = rise | fall;
         default:  cap_hit = 1'b0;           // capture disabled
      endcase
   end

   // live compare; a fresh match write is compared at once, so a request
   // can follow the rewrite directly, which is why software masks first
   assign hit = (s_reg.count == s_reg.match);

   // buzzer tap: wave period is count clock over 2^(4+code), so the wave
   // toggles each time the low 3+code divider bits are all ones
   always_comb
   begin
      bmask = ~({BUZZ_DIV_W{1'b1}} << (BUZZ_MIN_TAP - 1 + int'(bsel)));
      btap  = ((s_reg.bdiv & bmask) == bmask);
   end

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      s_next          = s_reg;
      s_next.cap_prev = capture_trigger_pin;
      s_next.irq      = 1'b0;

      // counting never stops on a match and runs through wake-up settling
      if (tick)
      begin
         s_next.count = s_reg.count + 16'h0001;
         s_next.bdiv  = s_reg.bdiv + 1'b1;
         if (s_reg.count == 16'hFFFF)
            s_next.mode[MODE_WRAP_BIT] = 1'b1;
      end

      // timer output flips on a counted match when inversion is enabled
      if (hit && tick && s_reg.mode[MODE_INV_EN_BIT])
         s_next.out_lvl = ~s_reg.out_lvl;

      // buzzer wave toggles while enabled, else parked low
      if (!s_reg.buzz[BUZZ_EN_BIT])
         s_next.bz = 1'b0;
      else if (tick && btap)
         s_next.bz = ~s_reg.bz;

      // capture copies the live counter on the chosen edge
      if (cap_hit)
         s_next.snap = s_reg.count;

      // register writes; byte writes touch one half only
      if (wr)
      begin
         case (addr)
            ADDR_MATCH_LO:
            begin
               if (word)
                  s_next.match = wdata;
               else
                  s_next.match[7:0] = wdata[7:0];
            end
            ADDR_MATCH_HI: s_next.match[15:8] = wdata[7:0];
            ADDR_MODE:
            begin
               // output data bit read only; wrap flag only cleared by writing 0
               s_next.mode[MODE_OUT_DATA_BIT-1:0] = wdata[MODE_OUT_DATA_BIT-1:0];
               s_next.mode[MODE_WRAP_BIT] = (s_reg.mode[MODE_WRAP_BIT] & wdata[MODE_WRAP_BIT])
                                            | (tick && s_reg.count == 16'hFFFF);
            end
            ADDR_BUZZ: s_next.buzz = {4'h0, wdata[3:0]};
            default:   ;  // counter and snapshot are read only
         endcase
      end

      // match request: a counted match, or a match write landing on the
      // value the counter holds next; never two pulses back to back
      match_wr = wr && (addr == ADDR_MATCH_LO || addr == ADDR_MATCH_HI);
      if (!s_reg.irq && ((hit && tick) || (match_wr && s_next.match == s_next.count)))
         s_next.irq = 1'b1;

      // reads; low byte read fills the buffer so the high read pairs up
      s_next.rdata = 16'h0000;
      if (rd)
      begin
         case (addr)
            ADDR_COUNT_LO:
            begin
               s_next.rbuf  = s_reg.count;
               s_next.rdata = word ? s_reg.count : {8'h00, s_reg.count[7:0]};
            end
            ADDR_COUNT_HI: s_next.rdata = {8'h00, s_reg.rbuf[15:8]};
            ADDR_MATCH_LO: s_next.rdata = word ? s_reg.match : {8'h00, s_reg.match[7:0]};
            ADDR_MATCH_HI: s_next.rdata = {8'h00, s_reg.match[15:8]};
            ADDR_SNAP_LO:  s_next.rdata = word ? s_reg.snap : {8'h00, s_reg.snap[7:0]};
            ADDR_SNAP_HI:  s_next.rdata = {8'h00, s_reg.snap[15:8]};
            ADDR_MODE:     s_next.rdata = {8'h00, s_reg.out_lvl, s_reg.mode[6:0]};
            ADDR_BUZZ:     s_next.rdata = {8'h00, s_reg.buzz};
            default:       s_next.rdata = 16'h0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register; snapshot gets zero only as a tidy start, software must
   // treat it as meaningless before the first capture
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_reg       <= '0;
         s_reg.count <= COUNT_RESET;
         s_reg.match <= MATCH_RESET;
         s_reg.mode  <= MODE_RESET;
         s_reg.buzz  <= BUZZ_RESET;
         s_reg.snap  <= 16'h0000;
      end
      else
         s_reg <= s_next;
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign rdata          = s_reg.rdata;
   assign match_irq      = s_reg.irq;
   assign timer_out_pin  = s_reg.mode[MODE_OUT_EN_BIT] & s_reg.out_lvl;
   assign buzzer_out_pin = s_reg.bz;

endmodule

//--- tb/match_timer_monitor.sv
// port-level assertions for the match timer
`timescale 1ns/1ps
module match_timer_monitor
   import match_timer_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic [3:0]  addr,
   input wire logic        rd,
   input wire logic        wr,
   input wire logic        word,
   input wire logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic        capture_trigger_pin,
   input wire logic        match_irq,
   input wire logic        timer_out_pin,
   input wire logic        buzzer_out_pin
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // word write to the match register, then its word read
   sequence s_match_wr;
      wr && word && addr == ADDR_MATCH_LO;
   endsequence
   sequence s_match_rd;
      rd && word && addr == ADDR_MATCH_LO;
   endsequence
   a_reset_quiet: assert property ($rose(rst_n) |-> !rdata && !match_irq && !timer_out_pin && !buzzer_out_pin)
      else $error("outputs not quiet after reset");
   a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
      else $error("read data without a read");
   a_unmapped_zero: assert property (rd && addr[3] |=> rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_match_readback: assert property (s_match_wr ##1 !wr ##1 s_match_rd |=> rdata == $past(wdata, 3))
      else $error("match word read back wrong");
   a_irq_pulse: assert property (match_irq |=> !match_irq [*3])
      else $error("match request too long");
   a_buzz_quiet: assert property (wr && !word && addr == ADDR_BUZZ && !wdata[BUZZ_EN_BIT] |-> ##2 !buzzer_out_pin)
      else $error("buzzer active while off");
   a_tout_quiet: assert property (wr && !word && addr == ADDR_MODE && !wdata[MODE_OUT_EN_BIT] |-> ##2 !timer_out_pin)
      else $error("timer output while off");
   a_tout_cause: assert property ($changed(timer_out_pin) |-> $past(wr) || $past(wr, 2) || match_irq)
      else $error("timer output moved without cause");
endmodule
bind match_timer match_timer_monitor u_match_timer_monitor (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr),
   .rd(rd), .wr(wr), .word(word), .wdata(wdata), .rdata(rdata), .capture_trigger_pin(capture_trigger_pin),
   .match_irq(match_irq), .timer_out_pin(timer_out_pin), .buzzer_out_pin(buzzer_out_pin));

//--- tb/tb.sv
// self-checking bench for the match timer
`timescale 1ns/1ps
module tb;
   import match_timer_pkg::*;
   logic        clk_sys, rst_n, rd, wr, word, capture_trigger_pin;
   logic [3:0]  addr;
   logic [15:0] wdata, rdata, v, w;
   logic        match_irq, timer_out_pin, buzzer_out_pin;
   int          miscompares, checks_done, n;
   match_timer u_match_timer (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .rd(rd), .wr(wr), .word(word),
      .wdata(wdata), .rdata(rdata), .capture_trigger_pin(capture_trigger_pin), .match_irq(match_irq),
      .timer_out_pin(timer_out_pin), .buzzer_out_pin(buzzer_out_pin));
   initial
   begin
      clk_sys = 0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one access, strobe held a single edge; read data taken the cycle after
   task automatic bus(input logic is_wr, input logic [3:0] a, input logic is_word, input logic [15:0] d);
      @(posedge clk_sys) #1;
      wr = is_wr;
      rd = !is_wr;
      addr = a;
      word = is_word;
      wdata = d;
      @(posedge clk_sys) #1;
      wr = 0;
      rd = 0;
      v = rdata;
   endtask
   task automatic mode(input logic [7:0] m);
      bus(1, ADDR_MODE, 0, {8'h00, m});
   endtask
   // bounded wait on the match pulse or the buzzer level
   task automatic wait_sig(input logic buz, input logic lvl);
      n = 0;
      while ((buz ? buzzer_out_pin : match_irq) !== lvl && n < 1000)
      begin
         @(posedge clk_sys) #1;
         n++;
      end
      if (n >= 1000)
      begin
         miscompares++;
         give_verdict();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      bus(0, ADDR_COUNT_LO, 1, 0);
      cmp("count", 16'h0000, v & 16'hFFFE);
      bus(0, ADDR_MATCH_LO, 1, 0);
      cmp("match", 16'hFFFF, v);
      bus(0, ADDR_MODE, 0, 0);
      cmp("mode", 16'h0000, v);
      bus(0, ADDR_BUZZ, 0, 0);
      cmp("buzz", 16'h0000, v);
      bus(0, 4'h9, 0, 0);
      cmp("unmapped", 16'h0000, v);
      bus(1, ADDR_MATCH_LO, 1, 16'h0000);
      bus(0, ADDR_MATCH_LO, 1, 0);
      cmp("match_zero", 16'h0000, v);
      $display("reset test done");
   endtask
   // byte writes, read-only counter, buffered high byte
   task automatic t_bytes;
      logic [15:0] z;
      mode(8'h06);
      bus(1, ADDR_MATCH_LO, 0, 16'h0034);
      bus(1, ADDR_MATCH_HI, 0, 16'h0012);
      bus(0, ADDR_MATCH_LO, 1, 0);
      cmp("match_bytes", 16'h1234, v);
      bus(0, ADDR_COUNT_LO, 1, 0);
      w = v;
      bus(1, ADDR_COUNT_LO, 1, 16'h5A5A);
      bus(0, ADDR_COUNT_LO, 1, 0);
      cmp("count_ro", w, v);
      bus(0, ADDR_COUNT_LO, 0, 0);
      cmp("count_lo", {8'h00, w[7:0]}, v);
      mode(8'h00);
      bus(0, ADDR_COUNT_LO, 0, 0);
      z = v;
      repeat (1100) @(posedge clk_sys);
      bus(0, ADDR_COUNT_HI, 0, 0);
      z[15:8] = v[7:0];
      mode(8'h06);
      bus(0, ADDR_COUNT_LO, 1, 0);
      cmp("count_pair", 16'h0001, {15'h0000, (v - z) > 16'h0100 && (v - z) < 16'h012C});
      cmp("counting", 16'h0001, {15'h0000, v > w});
      $display("byte test done");
   endtask
   // match write while equal raises the request, unequal does not
   task automatic t_write_irq;
      bus(0, ADDR_COUNT_LO, 1, 0);
      w = v;
      for (int i = 1; i >= 0; i--)
      begin
         bus(1, ADDR_MATCH_LO, 1, w + 16'(i));
         v[0] = match_irq;
         @(posedge clk_sys) #1;
         cmp("write_irq", 16'(1 - i), {15'h0000, v[0] | match_irq});
      end
      $display("write irq test done");
   endtask
   // match interval and output toggling for one divider
   task automatic t_rate(input logic [1:0] sel, input int div);
      logic    lvl;
      realtime t0;
      mode({5'h00, sel, 1'b1});
      bus(0, ADDR_COUNT_LO, 1, 0);
      w = v + 16'h0008;
      bus(1, ADDR_MATCH_LO, 1, w);
      mode({5'h01, sel, 1'b1});
      wait_sig(0, 1);
      t0 = $realtime;
      mode({5'h00, sel, 1'b1});
      bus(1, ADDR_MATCH_LO, 1, w + 16'h0003);
      mode({5'h01, sel, 1'b1});
      lvl = timer_out_pin;
      wait_sig(0, 1);
      cmp("interval", 16'(3 * div), 16'(int'(($realtime - t0) / 25.0)));
      @(posedge clk_sys) #1;
      cmp("timer_out", {15'h0000, ~lvl}, {15'h0000, timer_out_pin});
      $display("rate test done");
   endtask
   // every capture mode against rising and falling pin edges
   task automatic t_cap;
      for (int i = 0; i < 8; i++)
      begin
         mode({2'h0, 2'((i / 2 + 1) % 4), 4'h0});
         repeat (40) @(posedge clk_sys);
         mode({2'h0, 2'((i / 2 + 1) % 4), 4'h6});
         bus(0, ADDR_COUNT_LO, 1, 0);
         if ((8'h39 >> i) & 1)
            w = v;
         capture_trigger_pin = ~capture_trigger_pin;
         repeat (3) @(posedge clk_sys);
         bus(0, ADDR_SNAP_LO, 1, 0);
         cmp("snapshot", w, v);
      end
      $display("capture test done");
   endtask
   // buzzer period for two frequency codes, then off
   task automatic t_buzz;
      realtime t0;
      mode(8'h00);
      for (int k = 0; k < 2; k++)
      begin
         bus(1, ADDR_BUZZ, 0, 16'(2 * k + 1));
         wait_sig(1, 0);
         wait_sig(1, 1);
         t0 = $realtime;
         wait_sig(1, 0);
         wait_sig(1, 1);
         cmp("buzz_period", 16'(64 << k), 16'(int'(($realtime - t0) / 25.0)));
      end
      bus(1, ADDR_BUZZ, 0, 16'h0000);
      $display("buzzer test done");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {rst_n, rd, wr, word, capture_trigger_pin} = '0;
      addr = '0;
      wdata = '0;
      miscompares = 0;
      checks_done = 0;
      repeat (2) @(posedge clk_sys);
      #1 rst_n = 1;
      t_reset();
      t_bytes();
      t_write_irq();
      t_rate(CLK_DIV4, 4);
      t_rate(CLK_DIV64, 64);
      t_rate(CLK_DIV16, 16);
      t_cap();
      t_buzz();
      give_verdict();
   end
endmodule
